// File: verilog/gpe_pkg.sv
// gpe_pkg: constants for the general-purpose event block
// assumes byte-wide system i/o accesses from the host bus
package gpe_pkg;
  // i/o byte addresses of the two banks (blocks are 32-bit aligned)
  localparam logic [15:0] GPE_BANK0_BASE    = 16'h0040;
  localparam logic [15:0] GPE_BANK1_BASE    = 16'h0044;
  localparam int          GPE_BANK_WIDTH    = 8;
  localparam int          GPE_BLOCK_LEN     = 2;
  localparam logic [15:0] GPE_STS_OFFSET    = 16'h0000;
  localparam logic [15:0] GPE_EN_OFFSET     = 16'h0001;
  // generic i/o space bits
  localparam logic [15:0] GPE_POL33_ADDR    = 16'h0033;
  localparam int          GPE_POL33_BIT     = 2;
  localparam logic [15:0] GPE_COVER_CTL     = 16'h0201;
  localparam logic [15:0] GPE_COVER_STS     = 16'h0202;
  localparam int          GPE_COVER_POL_BIT = 0;
  localparam int          GPE_COVER_FLG_BIT = 1;
  localparam logic [15:0] GPE_EC_QUERY_ADDR = 16'h0062;
  localparam logic [7:0]  GPE_EC_QUERY_CMD  = 8'h84;
  // event wiring in bank 0
  localparam int          GPE_COVER_EVT     = 1;
  localparam int          GPE_EC_EVT        = 0;
  localparam int          GPE_RING_EVT      = 2;
  // query answers
  localparam logic [7:0]  GPE_QRY_MAINS     = 8'h22;
  localparam logic [7:0]  GPE_QRY_DOCK      = 8'h23;
  localparam logic [7:0]  GPE_QRY_NONE      = 8'h00;
  localparam logic [7:0]  GPE_RST_VAL       = 8'h00;
  typedef enum logic [1:0] {
    GPE_EC_IDLE  = 2'b00,
    GPE_EC_PEND  = 2'b01
  } gpe_ec_e;
endpackage

// File: verilog/gpe_bank_if.sv
// gpe_bank_if: per-bank status/enable carrier between top and bank
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface gpe_bank_if #(parameter int W = 8);
  logic [W-1:0] evt;
  logic [W-1:0] sts_w1c;
  logic         en_we;
  logic [W-1:0] en_wdata;
  logic [W-1:0] sts;
  logic [W-1:0] en;
  logic         pend;
  modport top (output evt, output sts_w1c, output en_we, output en_wdata,
               input sts, input en, input pend);
  modport bank (input evt, input sts_w1c, input en_we, input en_wdata,
                output sts, output en, output pend);
endinterface
`default_nettype wire

// File: verilog/gpe_bank.sv
// gpe_bank: one status/enable register pair
// assumes events are synchronous active-high levels
`timescale 1ns/1ps
`default_nettype none
module gpe_bank
  import gpe_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // register side
  gpe_bank_if.bank  bk
);
  logic [W-1:0] sts_q, sts_d, en_q, en_d;

  always_comb begin
    // set wins over a write-one clear
    sts_d = (sts_q & ~bk.sts_w1c) | bk.evt;
    en_d  = bk.en_we ? bk.en_wdata : en_q;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sts_q <= W'(GPE_RST_VAL);
      en_q  <= W'(GPE_RST_VAL);
    end else begin
      sts_q <= sts_d;
      en_q  <= en_d;
    end
  end

  assign bk.sts  = sts_q;
  assign bk.en   = en_q;
  assign bk.pend = |(sts_q & en_q);

  a_sts_set_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (bk.evt != '0) |=> ((sts_q & $past(bk.evt)) == $past(bk.evt)))
    else $error("event bit not set");
  a_sts_only_w1c: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((sts_q & ~bk.sts_w1c) != '0) |=> ((sts_q & $past(sts_q & ~bk.sts_w1c)) == $past(sts_q & ~bk.sts_w1c)))
    else $error("status lost without write one");
endmodule
`default_nettype wire

// File: verilog/gpe_top.sv
// gpe_top: general-purpose event block with cover switch and ec query
// assumes host does byte i/o reads and writes, one cycle strobes
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - active event sets its status bit
// - only a written one clears status
// - status pairs with same-position enable bit
// - enabled set status raises the interrupt
// - enabled status wakes a sleeping system
// - byte accesses, each lane decoded alone
// - status first half, enable second half
// - all status and enable reset zero
// - cover flag sets when level matches polarity
// - polarity also at bit 2 of 33h
// - cover control 0x201, status 0x202
// - cover flag feeds bank0 bit one
// - child flags propagate without own enables
// - mains detect gives query value 34
// - docking event gives query value 35
// - two banks, each 32-bit aligned
//////////////////////////////////////////////////////////////////////////////
module gpe_top
  import gpe_pkg::*;
#(
  parameter int W = GPE_BANK_WIDTH
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // system i/o byte port
  input  wire logic [15:0]  io_addr,
  input  wire logic         io_wr,
  input  wire logic         io_rd,
  input  wire logic [7:0]   io_wdata,
  output var  logic [7:0]   io_rdata,
  output var  logic         io_hit,
  // event inputs
  input  wire logic [W-1:0] evt_bank0_in,
  input  wire logic [W-1:0] evt_bank1_in,
  input  wire logic         cover_level,
  input  wire logic         mains_detect_n,
  input  wire logic         docking_event,
  // system side
  input  wire logic         sleeping,
  output var  logic         system_control_interrupt,
  output var  logic         wake_request
);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  gpe_bank_if #(.W(W)) b0 ();
  gpe_bank_if #(.W(W)) b1 ();

  gpe_bank #(.W(W)) u_bank0 (.clk_sys(clk_sys), .sys_rst(sys_rst), .bk(b0));
  gpe_bank #(.W(W)) u_bank1 (.clk_sys(clk_sys), .sys_rst(sys_rst), .bk(b1));

  //////////////////////////////////////////////////////////////////////////////
  // cover switch child logic
  logic cover_pol_q, cover_pol_d, cover_flag_q, cover_flag_d;
  logic cover_match;
  logic wr_ctl, wr_sts, wr_p33;

  assign wr_ctl = io_wr && hit(io_addr, GPE_COVER_CTL);
  assign wr_sts = io_wr && hit(io_addr, GPE_COVER_STS);
  assign wr_p33 = io_wr && hit(io_addr, GPE_POL33_ADDR);
  assign cover_match = (cover_level == cover_pol_q);

  always_comb begin
    cover_pol_d = cover_pol_q;
    if (wr_ctl) begin
      cover_pol_d = io_wdata[GPE_COVER_POL_BIT];
    end else if (wr_p33) begin
      cover_pol_d = io_wdata[GPE_POL33_BIT];
    end
    // child flag: write-one clear, set wins
    cover_flag_d = (cover_flag_q & ~(wr_sts & io_wdata[GPE_COVER_FLG_BIT]))
                   | cover_match;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cover_pol_q  <= 1'b0;
      cover_flag_q <= 1'b0;
    end else begin
      cover_pol_q  <= cover_pol_d;
      cover_flag_q <= cover_flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // embedded controller query events; docking child has no enable
  logic   mains_q, mains_d, dock_q, dock_d;
  logic   ec_rd_qry, ec_active;
  logic [7:0] qry_val;
  gpe_ec_e ec_state;

  assign ec_rd_qry = io_rd && hit(io_addr, GPE_EC_QUERY_ADDR);

  always_comb begin
    // a query read retires the highest waiting event, new events still latch
    mains_d = mains_q | ~mains_detect_n;
    dock_d  = dock_q | docking_event;
    qry_val = GPE_QRY_NONE;
    if (mains_q) begin
      qry_val = GPE_QRY_MAINS;
    end else if (dock_q) begin
      qry_val = GPE_QRY_DOCK;
    end
    if (ec_rd_qry && mains_q) begin
      mains_d = ~mains_detect_n;
    end else if (ec_rd_qry && dock_q) begin
      dock_d = docking_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mains_q <= 1'b0;
      dock_q  <= 1'b0;
    end else begin
      mains_q <= mains_d;
      dock_q  <= dock_d;
    end
  end

  assign ec_active = mains_q | dock_q;
  assign ec_state  = ec_active ? GPE_EC_PEND : GPE_EC_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // parent event wiring and register decode
  logic sel_s0, sel_e0, sel_s1, sel_e1;

  always_comb begin
    b0.evt = evt_bank0_in;
    b0.evt[GPE_COVER_EVT] = evt_bank0_in[GPE_COVER_EVT] | cover_flag_q;
    b0.evt[GPE_EC_EVT] = evt_bank0_in[GPE_EC_EVT] | (ec_state == GPE_EC_PEND);
    b1.evt = evt_bank1_in;
  end

  // each byte address decodes alone; status first, enable second half
  assign sel_s0 = hit(io_addr, GPE_BANK0_BASE + GPE_STS_OFFSET);
  assign sel_e0 = hit(io_addr, GPE_BANK0_BASE + GPE_EN_OFFSET);
  assign sel_s1 = hit(io_addr, GPE_BANK1_BASE + GPE_STS_OFFSET);
  assign sel_e1 = hit(io_addr, GPE_BANK1_BASE + GPE_EN_OFFSET);

  assign b0.sts_w1c  = (io_wr && sel_s0) ? io_wdata[W-1:0] : '0;
  assign b1.sts_w1c  = (io_wr && sel_s1) ? io_wdata[W-1:0] : '0;
  assign b0.en_we    = io_wr && sel_e0;
  assign b1.en_we    = io_wr && sel_e1;
  assign b0.en_wdata = io_wdata[W-1:0];
  assign b1.en_wdata = io_wdata[W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // read data registered; unmapped addresses read zero
  logic [7:0] rdata_d, rdata_q;
  logic       hit_d, hit_q;

  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b0;
    if (io_rd) begin
      hit_d = 1'b1;
      if (sel_s0) begin
        rdata_d = 8'(b0.sts);
      end else if (sel_e0) begin
        rdata_d = 8'(b0.en);
      end else if (sel_s1) begin
        rdata_d = 8'(b1.sts);
      end else if (sel_e1) begin
        rdata_d = 8'(b1.en);
      end else if (hit(io_addr, GPE_COVER_CTL)) begin
        rdata_d[GPE_COVER_POL_BIT] = cover_pol_q;
      end else if (hit(io_addr, GPE_COVER_STS)) begin
        rdata_d[GPE_COVER_FLG_BIT] = cover_flag_q;
      end else if (hit(io_addr, GPE_POL33_ADDR)) begin
        rdata_d[GPE_POL33_BIT] = cover_pol_q;
      end else if (ec_rd_qry) begin
        rdata_d = qry_val;
      end else begin
        hit_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  assign io_rdata = rdata_q;
  assign io_hit   = hit_q;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt is a plain level, no latch, so it drops as soon as bits clear
  assign system_control_interrupt = b0.pend | b1.pend;
  assign wake_request = sleeping & (b0.pend | b1.pend);

  a_sci_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    system_control_interrupt == (|(b0.sts & b0.en) || |(b1.sts & b1.en)))
    else $error("interrupt level wrong");
  a_wake_sleep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wake_request |-> (sleeping && system_control_interrupt))
    else $error("wake without sleep or event");
  a_cover_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cover_level == cover_pol_q) |=> cover_flag_q)
    else $error("cover flag not set");
  a_cover_parent: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cover_flag_q |=> b0.sts[GPE_COVER_EVT])
    else $error("cover parent not set");
  a_mains_query: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ec_rd_qry && mains_q) |=> (io_rdata == GPE_QRY_MAINS))
    else $error("mains query wrong");
  a_dock_query: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ec_rd_qry && !mains_q && dock_q) |=> (io_rdata == GPE_QRY_DOCK))
    else $error("dock query wrong");
  a_en_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_wr && sel_e0) |=> (b0.en == $past(io_wdata[W-1:0])))
    else $error("enable write lost");
  a_ec_parent: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ec_active |=> b0.sts[GPE_EC_EVT])
    else $error("ec parent not set");

  //////////////////////////////////////////////////////////////////////////////
  // steps of a transfer or of an event chain are named sequences below
  sequence s_rd_mapped;
    io_rd && (sel_s0 || sel_e0 || sel_s1 || sel_e1 || ec_rd_qry);
  endsequence

  sequence s_rd_none;
    !io_rd;
  endsequence

  sequence s_pol_write;
    wr_ctl || wr_p33;
  endsequence

  // the flag follows the match by one edge, the parent one edge later
  sequence s_cover_seen;
    cover_match ##1 cover_flag_q;
  endsequence

  sequence s_mains_retire;
    ec_rd_qry && mains_q && mains_detect_n;
  endsequence

  sequence s_dock_retire;
    ec_rd_qry && !mains_q && dock_q && !docking_event;
  endsequence

  a_read_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_rd_mapped |=> io_hit)
    else $error("mapped read not answered");
  a_read_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_rd_none |=> ((io_rdata == 8'h00) && !io_hit))
    else $error("read data without a read");
  a_pol_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_pol_write |=> (cover_pol_q == ($past(wr_ctl) ? $past(io_wdata[GPE_COVER_POL_BIT])
                                                   : $past(io_wdata[GPE_POL33_BIT]))))
    else $error("polarity write lost");
  a_cover_chain: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_cover_seen |=> b0.sts[GPE_COVER_EVT])
    else $error("cover event did not reach bank 0");
  a_cover_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_sts && io_wdata[GPE_COVER_FLG_BIT] && !cover_match) |=> !cover_flag_q)
    else $error("cover flag not cleared");
  a_mains_retire: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_mains_retire |=> !mains_q)
    else $error("query read kept mains event");
  a_dock_retire: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_dock_retire |=> !dock_q)
    else $error("query read kept docking event");
  a_sts1_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_wr && sel_s1) |=> ((b1.sts & $past(io_wdata[W-1:0]) & ~$past(b1.evt)) == '0))
    else $error("bank 1 status not cleared");
  a_en1_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_wr && sel_e1) |=> (b1.en == $past(io_wdata[W-1:0])))
    else $error("bank 1 enable write lost");
  a_wake_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sleeping && system_control_interrupt) |-> wake_request)
    else $error("no wake while sleeping with event");
  // no disable here: this one is about the reset itself
  a_rst_clear: assert property (@(posedge clk_sys)
    sys_rst |=> ((b0.sts == '0) && (b0.en == '0) && (b1.sts == '0) && (b1.en == '0)
                 && !cover_pol_q && !cover_flag_q && !mains_q && !dock_q))
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

// File: tb/gpe_evt_src.sv
// gpe_evt_src: platform event pins around the event block
// assumes pins change on the rising clock edge only
`timescale 1ns/1ps
`default_nettype none
module gpe_evt_src (
  // clock
  input  wire logic       clk_sys,
  // event pins
  output var  logic [7:0] evt_b0,
  output var  logic [7:0] evt_b1,
  output var  logic       cover_lvl,
  output var  logic       mains_n,
  output var  logic       dock
);
  // unused pins rest inactive so no floating input sets a flag
  initial begin
    evt_b0    = 8'h00;
    evt_b1    = 8'h00;
    cover_lvl = 1'b1;
    mains_n   = 1'b1;
    dock      = 1'b0;
  end
  task automatic drive(input logic [7:0] b0, input logic [7:0] b1, input logic cv,
                       input logic mn, input logic dk);
    @(posedge clk_sys);
    evt_b0    <= b0;
    evt_b1    <= b1;
    cover_lvl <= cv;
    mains_n   <= mn;
    dock      <= dk;
  endtask
endmodule
`default_nettype wire

// File: tb/general_purpose_event_block_tb.sv
// general_purpose_event_block_tb: byte i/o tests of the event block
// assumes one-cycle strobes and read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module general_purpose_event_block_tb;
  import gpe_pkg::*;
  logic        clk_sys, sys_rst, io_wr, io_rd, io_hit, sleeping, irq, wake;
  logic        cv, mn, dk;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, b0, b1;
  int          failures, total_checks;
  localparam logic [15:0] S0 = GPE_BANK0_BASE + GPE_STS_OFFSET;
  localparam logic [15:0] S1 = GPE_BANK1_BASE + GPE_STS_OFFSET;
  localparam logic [15:0] E0 = GPE_BANK0_BASE + GPE_EN_OFFSET;
  localparam logic [15:0] E1 = GPE_BANK1_BASE + GPE_EN_OFFSET;
  //////////////////////////////////////////////////////////////////////////////
  gpe_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .evt_bank0_in(b0), .evt_bank1_in(b1), .cover_level(cv), .mains_detect_n(mn),
    .docking_event(dk), .sleeping(sleeping), .system_control_interrupt(irq),
    .wake_request(wake));
  gpe_evt_src src (.clk_sys(clk_sys), .evt_b0(b0), .evt_b1(b1), .cover_lvl(cv),
    .mains_n(mn), .dock(dk));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk_sys);
    io_wr    <= 1'b0;
    #1;
  endtask
  // request is taken at the second edge; data stands just after that same edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk_sys);
    io_rd   <= 1'b0;
    #1;
    chk($sformatf("rdata %h", a), e, io_rdata);
    chk($sformatf("hit %h", a), {7'h00, h}, {7'h00, io_hit});
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // whole run is about a hundred cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    sleeping = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(S0, GPE_RST_VAL, 1'b1);
    rd(E0, GPE_RST_VAL, 1'b1);
    rd(S1, GPE_RST_VAL, 1'b1);
    rd(E1, GPE_RST_VAL, 1'b1);
    rd(16'h0042, 8'h00, 1'b0);
    wr(E1, 8'h5A);
    rd(E1, 8'h5A, 1'b1);
    rd(S1, 8'h00, 1'b1);
    // a bank 0 pin latches while its enable is off, so no interrupt follows
    src.drive(8'h80, 8'h00, 1'b1, 1'b1, 1'b0);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    rd(S0, 8'h80, 1'b1);
    chk("irq", 8'h00, {7'h00, irq});
    wr(S0, 8'h80);
    rd(S0, 8'h00, 1'b1);
    src.drive(8'h00, 8'h09, 1'b1, 1'b1, 1'b0);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    rd(S1, 8'h09, 1'b1);
    @(posedge clk_sys);
    sleeping <= 1'b1;
    #1;
    chk("wake", 8'h01, {7'h00, wake});
    wr(S1, 8'h00);
    rd(S1, 8'h09, 1'b1);
    wr(S1, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    wr(S1, 8'h08);
    chk("irq", 8'h00, {7'h00, irq});
    chk("wake", 8'h00, {7'h00, wake});
    // event held across the clearing write keeps its bit
    src.drive(8'h00, 8'h10, 1'b1, 1'b1, 1'b0);
    wr(S1, 8'h10);
    rd(S1, 8'h10, 1'b1);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    wr(S1, 8'h10);
    rd(S1, 8'h00, 1'b1);
    src.drive(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    rd(S0, 8'h01, 1'b1);
    rd(GPE_EC_QUERY_ADDR, GPE_QRY_MAINS, 1'b1);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
    src.drive(8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
    rd(GPE_EC_QUERY_ADDR, GPE_QRY_DOCK, 1'b1);
    rd(GPE_EC_QUERY_ADDR, GPE_QRY_NONE, 1'b1);
    wr(S0, 8'h01);
    wr(E0, 8'h02);
    wr(GPE_COVER_CTL, 8'h01);
    rd(GPE_POL33_ADDR, 8'h04, 1'b1);
    rd(GPE_COVER_STS, 8'h02, 1'b1);
    rd(S0, 8'h02, 1'b1);
    chk("irq", 8'h01, {7'h00, irq});
    // level still matches at the clearing write, so set wins and the flag stays set
    wr(GPE_COVER_STS, 8'h02);
    wr(GPE_COVER_CTL, 8'h00);
    rd(GPE_COVER_STS, 8'h02, 1'b1);
    wr(GPE_COVER_STS, 8'h02);
    rd(GPE_COVER_STS, 8'h00, 1'b1);
    wr(S0, 8'h02);
    rd(S0, 8'h00, 1'b1);
    src.drive(8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
    rd(GPE_COVER_STS, 8'h02, 1'b1);
    // polarity through its second address; the other bits read as zero
    wr(GPE_POL33_ADDR, 8'h04);
    rd(GPE_COVER_CTL, 8'h01, 1'b1);
    wr(GPE_COVER_STS, 8'h02);
    rd(GPE_COVER_STS, 8'h00, 1'b1);
    // second reset in mid-run wipes what software left behind
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(E1, GPE_RST_VAL, 1'b1);
    rd(GPE_COVER_CTL, 8'h00, 1'b1);
    results();
  end
endmodule
`default_nettype wire
